// ==== rtl/dio_irq_port.sv ====
// Digital core of a 16-in, 16-out isolated I/O unit with per-bit interrupts.
// Assumes field inputs are asynchronous and software talks over Avalon-MM.
//
// Overview of operation
// R1: Sixteen filtered inputs, each usable as an interrupt source.
// R2: Sixteen software-set outputs driven to the field side.
// R3: All sixteen input interrupt conditions merge into one shared request.
// R4: Per-bit interrupt enable; a disabled bit never asserts the request.
// R5: Per-bit edge select: field high-to-low or low-to-high triggers.
// R6: Software-configured digital filter rejects noise before reporting or interrupts.
// R7: Reported input value is the inverse of the field level.
// R8: Written output value drives the inverse field level.
// R9: Logical zero is field high, logical one is field low.
// R10: Enabled edges set sticky pending flags; request holds until software clears.
`timescale 1ns/1ps
`default_nettype none

module dio_irq_port
  import dio_pkg::*;
#(
  parameter int unsigned N = CHANNELS
) (
  input wire logic clk, // System clock, 50 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic [N-1:0] field_in, // Raw field input levels.
  output logic [N-1:0] field_out, // Field output levels.
  input wire logic [ADDR_W-1:0] avs_address, // Register byte address.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte enables.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest, // Stall until the answer.
  output logic shared_interrupt_request // Level interrupt, active high.
);

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  // The stages reset to an idle field, so no edge appears after reset.
  logic [N-1:0] sync1_reg, sync1_next;
  logic [N-1:0] sync2_reg, sync2_next;

  // Two flip-flops bring the field levels into the clock domain.
  always_comb begin
    sync1_next = ce ? field_in : sync1_reg;
    sync2_next = ce ? sync1_reg : sync2_reg;
  end

  // Registers the synchroniser stages.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= FIELD_IDLE[N-1:0];
      sync2_reg <= FIELD_IDLE[N-1:0];
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // ****************************************************************
  // Filter tick
  // ****************************************************************
  // One tick counter serves all channels, which keeps the filters small.
  logic [15:0] tick_cnt_reg, tick_cnt_next;
  logic tick;
  logic [FILT_W-1:0] filt_cfg_reg, filt_cfg_next;

  // Divides the clock down to the filter sample rate.
  always_comb begin
    tick = (tick_cnt_reg == 16'(TICK_CYC - 1));
    tick_cnt_next = tick_cnt_reg;
    if (ce) begin
      tick_cnt_next = tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
    end
  end

  // Registers the tick counter.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // ****************************************************************
  // Per-channel filter and edge detection
  // ****************************************************************
  logic [N-1:0] stable_reg, stable_next;
  logic [N-1:0] rise_ev, fall_ev;
  logic [N-1:0] edge_sel_reg, edge_sel_next;

  // One copy of the filter and edge logic stands for each input channel.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_chan
      logic [FILT_W-1:0] cnt_reg, cnt_next;

      // A new level is accepted only after it holds for the configured ticks;
      // a setting of zero passes the synchronised level straight through.
      always_comb begin
        cnt_next = cnt_reg;
        stable_next[g] = stable_reg[g];
        if (ce) begin
          if (sync2_reg[g] == stable_reg[g]) begin
            cnt_next = '0;
          end else if (filt_cfg_reg == '0 || (tick && cnt_reg >= filt_cfg_reg - 1'b1)) begin
            stable_next[g] = sync2_reg[g]; // [R6]
            cnt_next = '0;
          end else if (tick) begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end

      // Registers the hold counter of this channel.
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_next;
        end
      end

      // Field falling edge is logical rise, and the reverse.
      assign fall_ev[g] = stable_reg[g] & ~stable_next[g];
      assign rise_ev[g] = ~stable_reg[g] & stable_next[g];
    end
  endgenerate

  // Registers the filtered field levels.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stable_reg <= FIELD_IDLE[N-1:0];
    end else begin
      stable_reg <= stable_next;
    end
  end

  // ****************************************************************
  // Interrupt status and request
  // ****************************************************************
  // Status, mask and output state; the request itself is registered for a clean pin.
  logic [N-1:0] status_reg, status_next;
  logic [N-1:0] mask_reg, mask_next;
  logic [N-1:0] out_reg, out_next;
  logic [N-1:0] field_out_reg, field_out_next;
  logic irq_reg, irq_next;
  logic [N-1:0] edge_hit, w1c;
  bus_req_s req;
  logic take;

  // Edge select one means field low-to-high, zero means field high-to-low.
  assign edge_hit = (edge_sel_reg & rise_ev) | (~edge_sel_reg & fall_ev); // [R5] [R1]

  // Enabled edges set sticky bits; a new edge beats a same-cycle clear.
  always_comb begin
    status_next = status_reg;
    if (ce) begin
      status_next = (status_reg & ~w1c) | (edge_hit & mask_reg); // [R4] [R10]
    end
    irq_next = |(status_next & mask_next); // [R3] [R4]
    field_out_next = ~out_next; // [R8] [R9] [R2]
  end

  // Registers status, request and field outputs.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_reg <= '0;
      irq_reg <= 1'b0;
      field_out_reg <= FIELD_IDLE[N-1:0];
    end else begin
      status_reg <= status_next;
      irq_reg <= irq_next;
      field_out_reg <= field_out_next;
    end
  end

  // Top outputs come straight from their flip-flops.
  assign shared_interrupt_request = irq_reg;
  assign field_out = field_out_reg;

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  // Every request is answered one cycle after it is taken, so a master never waits longer.
  bus_state_e bus_state_reg, bus_state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] rd_val;
  logic [31:0] be_mask;

  // The request pins travel as one bundle to the decode below.
  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 writedata: avs_writedata};
  assign take = ce && (bus_state_reg == BUS_IDLE) && (req.read || req.write);
  // Byte enables widen into a bit mask for the write merge.
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Selects the read value; unmapped offsets read zero.
  always_comb begin
    rd_val = READ_ZERO;
    if (req.address == OFS_IN_DATA) begin
      rd_val[N-1:0] = ~stable_reg; // [R7] [R9]
    end else if (req.address == OFS_OUT_DATA) begin
      rd_val[N-1:0] = out_reg;
    end else if (req.address == OFS_IRQ_STATUS) begin
      rd_val[N-1:0] = status_reg;
    end else if (req.address == OFS_IRQ_MASK) begin
      rd_val[N-1:0] = mask_reg;
    end else if (req.address == OFS_IRQ_EDGE) begin
      rd_val[N-1:0] = edge_sel_reg;
    end else if (req.address == OFS_FILT_CFG) begin
      rd_val[FILT_W-1:0] = filt_cfg_reg;
    end
  end

  // Writes land in the cycle the request is taken; the answer follows one cycle later.
  always_comb begin
    bus_state_next = bus_state_reg;
    rdata_next = rdata_reg;
    out_next = out_reg;
    mask_next = mask_reg;
    edge_sel_next = edge_sel_reg;
    filt_cfg_next = filt_cfg_reg;
    w1c = '0;
    if (ce) begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (take) begin
            bus_state_next = BUS_DONE;
            rdata_next = req.read ? rd_val : READ_ZERO;
          end
          if (take && req.write) begin
            if (req.address == OFS_OUT_DATA) begin
              out_next = (out_reg & ~be_mask[N-1:0]) | (req.writedata[N-1:0] & be_mask[N-1:0]);
            end else if (req.address == OFS_IRQ_STATUS) begin
              w1c = req.writedata[N-1:0] & be_mask[N-1:0]; // [R10]
            end else if (req.address == OFS_IRQ_MASK) begin
              mask_next = (mask_reg & ~be_mask[N-1:0]) | (req.writedata[N-1:0] & be_mask[N-1:0]);
            end else if (req.address == OFS_IRQ_EDGE) begin
              edge_sel_next = (edge_sel_reg & ~be_mask[N-1:0]) |
                              (req.writedata[N-1:0] & be_mask[N-1:0]);
            end else if (req.address == OFS_FILT_CFG) begin
              filt_cfg_next = (filt_cfg_reg & ~be_mask[FILT_W-1:0]) |
                              (req.writedata[FILT_W-1:0] & be_mask[FILT_W-1:0]);
            end
          end
        end
        BUS_DONE: begin
          bus_state_next = BUS_IDLE;
        end
        default: begin
          bus_state_next = BUS_IDLE;
        end
      endcase
    end
  end

  // Registers the bus state and the settings that software sees.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_state_reg <= BUS_IDLE;
      rdata_reg <= READ_ZERO;
      out_reg <= RST_OUT[N-1:0];
      mask_reg <= RST_MASK[N-1:0];
      edge_sel_reg <= RST_EDGE[N-1:0];
      filt_cfg_reg <= RST_FILT;
    end else begin
      bus_state_reg <= bus_state_next;
      rdata_reg <= rdata_next;
      out_reg <= out_next;
      mask_reg <= mask_next;
      edge_sel_reg <= edge_sel_next;
      filt_cfg_reg <= filt_cfg_next;
    end
  end

  // Waitrequest is low only in the answer cycle, so it comes from a flip-flop.
  logic wait_reg, wait_next;
  always_comb begin
    wait_next = wait_reg;
    if (ce) begin
      wait_next = !take;
    end
  end

  // Registers the wait state; it rests high after reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= wait_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  // Read data stand from the answer cycle until the next answer.
  assign avs_readdata = rdata_reg;

endmodule

`default_nettype wire

// ==== rtl/dio_pkg.sv ====
// Shared constants and types for the isolated digital I/O port with interrupts.
// Assumes a 50 MHz system clock and a 32-bit Avalon-MM register bus.
package dio_pkg;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int unsigned CHANNELS = 16;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned FILT_W = 16;
  localparam int unsigned CLK_HZ = 50000000;
  // Filter tick period in nanoseconds; one tick is one filter sample.
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYC_RAW = (TICK_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned TICK_CYC = (TICK_CYC_RAW < 1) ? 1 : TICK_CYC_RAW;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_IN_DATA = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_DATA = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EDGE = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_FILT_CFG = 5'h14;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [CHANNELS-1:0] RST_OUT = 16'h0000;
  localparam logic [CHANNELS-1:0] RST_MASK = 16'h0000;
  localparam logic [CHANNELS-1:0] RST_EDGE = 16'h0000;
  localparam logic [FILT_W-1:0] RST_FILT = 16'h0000;
  localparam logic [CHANNELS-1:0] FIELD_IDLE = 16'hffff;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Bus answer state.
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_e;

  // Avalon-MM request carried as one bundle.
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
  } bus_req_s;

endpackage

// ==== dv/dio_port_monitor.sv ====
// Checker for the I/O port: bus timing, interrupt and output relations.
// Sees only the top ports and is bound into every port instance.
`timescale 1ns/1ps
`default_nettype none
module dio_port_monitor
  import dio_pkg::*;
#(
  parameter int unsigned N = CHANNELS
) (
  input wire logic clk, // Clock.
  input wire logic rstn, // Reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic [N-1:0] field_in, // Field inputs.
  input wire logic [N-1:0] field_out, // Field outputs.
  input wire logic [ADDR_W-1:0] avs_address, // Address.
  input wire logic avs_read, // Read.
  input wire logic avs_write, // Write.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte enables.
  input wire logic [31:0] avs_readdata, // Read data.
  input wire logic avs_waitrequest, // Stall.
  input wire logic shared_interrupt_request // Interrupt.
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  // An answered full-width write.
  wire logic wr_ok = avs_write && !avs_waitrequest && avs_byteenable == 4'hf;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  answer_time_a: assert property ($rose(avs_read) || $rose(avs_write) |=> !avs_waitrequest)
    else $error("answer not one cycle after request");
  idle_wait_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address > OFS_FILT_CFG |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  out_inverse_a: assert property (wr_ok && avs_address == OFS_OUT_DATA |=>
    field_out == ~$past(avs_writedata[15:0])) else $error("field output not inverse");
  mask_off_a: assert property (wr_ok && avs_address == OFS_IRQ_MASK &&
    avs_writedata[15:0] == 16'h0 |-> !shared_interrupt_request) else $error("masked irq");
  irq_hold_a: assert property (shared_interrupt_request && !avs_write |=>
    shared_interrupt_request) else $error("irq dropped without clear");
  cover property (avs_read && !avs_waitrequest);
  cover property ($rose(shared_interrupt_request));
  cover property (wr_ok && avs_address == OFS_IRQ_MASK);
endmodule
bind dio_irq_port dio_port_monitor #(.N(N)) dio_port_monitor_i (
  .clk(clk), .rstn(rstn), .ce(ce), .field_in(field_in), .field_out(field_out),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .shared_interrupt_request(shared_interrupt_request));
`default_nettype wire

// ==== dv/dio_field_model.sv ====
// Field-side model: presents logical input levels and reads outputs.
// Assumes the bench sets the logical pattern it wants the port to see.
`timescale 1ns/1ps
`default_nettype none
module dio_field_model (
  input wire logic clk, // Bench clock.
  input wire logic [15:0] level, // Logical input pattern.
  input wire logic [15:0] field_out, // Field outputs of the port.
  output logic [15:0] field_in, // Field input levels.
  output logic [15:0] out_value // Logical output value seen.
);
  // ****************************************************************
  // Level conversion
  // ****************************************************************
  // A logical one is a low field level, so inputs are driven inverted.
  always_ff @(posedge clk) field_in <= ~level;
  // Outputs are read back through the same inversion.
  assign out_value = ~field_out;
endmodule
`default_nettype wire

// ==== dv/dio_irq_port_test.sv ====
// Self-checking bench for the isolated I/O port.
// Assumes the field model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module dio_irq_port_test;
  import dio_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, irq, avs_waitrequest;
  logic ce = 1'b1;
  logic [4:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hf;
  logic [15:0] level = '0, field_in, field_out, out_value, v;
  logic [31:0] expq[$];
  int error_cnt = 0, comparisons = 0, seed = 32'h345a1aab;
  // ****************************************************************
  // Clock, port and field model
  // ****************************************************************
  always #10 clk = ~clk;
  dio_irq_port dio_irq_port_i (.clk(clk), .rstn(rstn), .ce(ce), .field_in(field_in),
    .field_out(field_out), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .shared_interrupt_request(irq));
  dio_field_model dio_field_model_i (.clk(clk), .level(level), .field_out(field_out),
    .field_in(field_in), .out_value(out_value));
  // Compares one value and counts it.
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One bus cycle, held until waitrequest is sampled low.
  task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      cmp("bus answer", 32'h1, 32'h0);
      results();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  // Notes the expected read data, then reads.
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b1, a, '0);
  endtask
  // Takes the oldest note whenever read data is answered.
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && expq.size() > 0) begin
      cmp("readdata", expq.pop_front(), avs_readdata);
    end
  end
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmp("field_out", 32'hffff, {16'h0, field_out});
    for (int a = 4; a < 32; a += 4) begin
      rd(a[4:0], '0);
    end
    wr(OFS_IN_DATA, '1);
    wr(5'h18, '1);
    rd(OFS_IN_DATA, '0);
    rd(5'h18, '0);
    v = 16'($random(seed));
    wr(OFS_OUT_DATA, {16'hffff, v});
    cmp("out_value", {16'h0, v}, {16'h0, out_value});
    rd(OFS_OUT_DATA, {16'h0, v});
    avs_byteenable <= 4'h1;
    wr(OFS_OUT_DATA, 32'h0000_a55a);
    avs_byteenable <= 4'hf;
    rd(OFS_OUT_DATA, {16'h0, v[15:8], 8'h5a});
    wr(OFS_IRQ_MASK, 32'hffff);
    v = 16'($random(seed)) | 16'h0001;
    level <= v;
    repeat (10) @(posedge clk);
    rd(OFS_IN_DATA, {16'h0, v});
    cmp("irq", 32'h1, {31'h0, irq});
    rd(OFS_IRQ_STATUS, {16'h0, v});
    wr(OFS_IRQ_STATUS, {16'h0, v});
    cmp("irq", 32'h0, {31'h0, irq});
    // Bit 0 goes field high, then falls while the clock enable holds every state.
    level <= v & 16'hfffe;
    repeat (10) @(posedge clk);
    ce <= 1'b0;
    level <= v;
    repeat (10) @(posedge clk);
    cmp("irq frozen", 32'h0, {31'h0, irq});
    ce <= 1'b1;
    repeat (10) @(posedge clk);
    cmp("irq", 32'h1, {31'h0, irq});
    rd(OFS_IRQ_STATUS, 32'h0001);
    wr(OFS_IRQ_STATUS, 32'h0001);
    wr(OFS_IRQ_EDGE, 32'hffff);
    level <= '0;
    repeat (10) @(posedge clk);
    rd(OFS_IRQ_STATUS, {16'h0, v});
    wr(OFS_IRQ_STATUS, 32'hffff);
    wr(OFS_IRQ_EDGE, '0);
    wr(OFS_IRQ_MASK, 32'h00ff);
    level <= 16'hff00;
    repeat (10) @(posedge clk);
    cmp("irq", 32'h0, {31'h0, irq});
    level <= '1;
    repeat (10) @(posedge clk);
    rd(OFS_IRQ_STATUS, 32'h00ff);
    wr(OFS_IRQ_MASK, '0);
    cmp("irq", 32'h0, {31'h0, irq});
    rd(OFS_IRQ_STATUS, 32'h00ff);
    wr(OFS_IRQ_STATUS, 32'hffff);
    wr(OFS_IRQ_MASK, 32'hffff);
    // Two ticks of hold, so a five-cycle glitch can never be accepted.
    wr(OFS_FILT_CFG, 32'h2);
    level <= '0;
    repeat (5) @(posedge clk);
    level <= '1;
    repeat (80) @(posedge clk);
    rd(OFS_IN_DATA, 32'hffff);
    cmp("irq", 32'h0, {31'h0, irq});
    level <= '0;
    repeat (150) @(posedge clk);
    rd(OFS_IN_DATA, '0);
    level <= 16'h8001;
    repeat (150) @(posedge clk);
    rd(OFS_IRQ_STATUS, 32'h8001);
    wr(OFS_IRQ_STATUS, 32'h8001);
    results();
  end
endmodule
`default_nettype wire
